// *** exit_mode_bounds_check.sv ***
// exit-mode stop sequencer and field-length bounds check
//
// The address map and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ps

module exit_mode_bounds_check
(
	// clock and reset
	input  wire logic                         clk,
	input  wire logic                         nrst,
	// wishbone slave
	input  wire logic                         wb_cyc_i,
	input  wire logic                         wb_stb_i,
	input  wire logic                         wb_we_i,
	input  wire logic [7:0]                   wb_adr_i,
	input  wire logic [31:0]                  wb_dat_i,
	input  wire logic [3:0]                   wb_sel_i,
	output logic      [31:0]                  wb_dat_o,
	output logic                              wb_ack_o,
	// memory requests from the processor
	input  wire logic                         req_valid,
	input  wire logic [17:0]                  req_addr,
	input  wire logic [5:0]                   req_tag,
	output logic                              req_ready,
	// hopper side
	input  wire logic                         hopper_grant,
	input  wire logic [5:0]                   hop_tag_chain,
	input  wire logic                         mem_accept,
	output logic                              hop_load,
	output exit_bounds_pkg::hop_req_type      hop_req,
	// issue and translator status
	input  wire logic                         exchange_active,
	input  wire logic                         third_skip_phase,
	input  wire logic [5:0]                   opcode_field,
	input  wire logic                         scoreboard_dispatch,
	input  wire logic                         fetch_next_pending,
	input  wire logic                         pc_update,
	input  wire logic [17:0]                  pc_value,
	// floating-point result flags
	input  wire logic                         fp_result_valid,
	input  wire logic [10:0]                  fp_exponent,
	input  wire logic                         fp_indefinite,
	// processor control outputs
	output logic                              stop,
	output logic                              instruction_word_fetch,
	output logic                              proceed,
	output logic                              jump_launch,
	output logic      [17:0]                  program_counter
);

	// registers
	logic [2:0]                       exit_selection_q;
	logic [17:0]                      field_length_q;
	logic [17:0]                      relocation_base_q;
	logic [17:0]                      bound_check_address_q;
	logic [5:0]                       bca_tag_q;
	logic                             bca_full_q;
	logic                             stop_q;
	logic                             oob_q;
	logic                             error_q;
	logic                             exit_q;
	logic                             fetch_q;
	logic                             proceed_q;
	logic                             jump_q;
	logic [2:0]                       code_q;
	logic [17:0]                      pc_q;
	logic [3:0]                       dly_q;
	logic [3:0]                       gap_q;
	logic                             hop_load_q;
	exit_bounds_pkg::hop_req_type     hop_q;
	exit_bounds_pkg::exit_state_type  state_q;
	exit_bounds_pkg::exit_state_type  state_d;
	logic                             ack_q;
	logic [31:0]                      rdata_q;

	// bus decode
	wire logic        bus_req   = wb_cyc_i & wb_stb_i & ~ack_q;
	wire logic        bus_wr    = bus_req & wb_we_i;
	wire logic [31:0] lane_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
		{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	wire logic        wr_sel    = bus_wr && wb_adr_i == exit_bounds_pkg::OFS_EXIT_SEL;
	wire logic        wr_fl     = bus_wr && wb_adr_i == exit_bounds_pkg::OFS_FL;
	wire logic        wr_ra     = bus_wr && wb_adr_i == exit_bounds_pkg::OFS_RA;
	wire logic        wr_stat   = bus_wr && wb_adr_i == exit_bounds_pkg::OFS_STATUS;
	wire logic [31:0] wr_bits   = wb_dat_i & lane_mask;
	wire logic        clr_stop  = wr_stat & wr_bits[exit_bounds_pkg::ST_STOP];
	wire logic        clr_oob   = wr_stat & wr_bits[exit_bounds_pkg::ST_OOB];
	wire logic        clr_fetch = wr_stat & wr_bits[exit_bounds_pkg::ST_FETCH];

	// continuous compare
	// digit-wise bitwise and octal-digit comparison of the held address
	logic [5:0] grp_ge;
	logic [5:0] dig_gt;
	logic [5:0] dig_eq;
	genvar g;
	for (g = 0; g < exit_bounds_pkg::DIGITS; g++)
	begin : g_digit
		wire logic [2:0] md = bound_check_address_q[3*g +: 3];
		wire logic [2:0] fd = field_length_q[3*g +: 3];
		assign grp_ge[g] = &(md | ~fd);
		assign dig_gt[g] = md > fd;
		assign dig_eq[g] = md == fd;
	end

	// digit cascade: each higher octal digit overrides the lower ones
	logic digit_cmp;
	always_comb
	begin
		digit_cmp = 1'b0;
		for (int i = 0; i < exit_bounds_pkg::DIGITS; i++)
		begin
			digit_cmp = dig_gt[i] | (dig_eq[i] & digit_cmp);
		end
	end

	wire logic bitwise_cmp  = |(dig_gt & ~grp_ge) | |(dig_gt & grp_ge);
	wire logic out_of_range = bitwise_cmp & digit_cmp;

	// request path into the bound check address register
	wire logic exit_busy  = state_q != exit_bounds_pkg::S_IDLE;
	wire logic exit_mode  = exit_busy | exit_q;
	assign req_ready      = ~bca_full_q & ~exit_busy & ~stop_q;
	wire logic take_req   = req_valid & req_ready;
	wire logic send_req   = bca_full_q & hopper_grant & ~exit_busy;

	// write bit and sum blocked
	// fetches and reads go out as tag 10; stores keep their low bits only
	wire logic [5:0]  oob_tag   = bca_tag_q[5] ? (bca_tag_q & ~exit_bounds_pkg::TAG_WRITE_BIT)
		: exit_bounds_pkg::TAG_FETCH;
	wire logic [17:0] reloc_sum = bound_check_address_q + relocation_base_q;

	wire logic [17:0] pc_plus1 = pc_q + 18'h00001;
	wire logic [59:0] exit_word = ({54'h0, exit_bounds_pkg::OPC_STOP}
		<< exit_bounds_pkg::EW_OPC_LSB)
		| ({57'h0, code_q} << exit_bounds_pkg::EW_CODE_LSB)
		| ({42'h0, pc_plus1} << exit_bounds_pkg::EW_ADDR_LSB);

	// hopper head selection
	logic                          hop_load_d;
	exit_bounds_pkg::hop_req_type  hop_d;
	always_comb
	begin
		hop_load_d = 1'b0;
		hop_d      = hop_q;
		if (state_q == exit_bounds_pkg::S_WRITE)
		begin
			hop_load_d = 1'b1;
			hop_d      = '{relocation_base_q, exit_bounds_pkg::TAG_EXIT_WR, exit_word};
		end
		else if (state_q == exit_bounds_pkg::S_FETCH)
		begin
			hop_load_d = 1'b1;
			hop_d      = '{relocation_base_q, exit_bounds_pkg::TAG_FETCH, 60'h0};
		end
		else if (send_req && out_of_range)
		begin
			hop_load_d = 1'b1;
			hop_d      = '{18'h0, oob_tag, 60'h0};
		end
		else if (send_req)
		begin
			hop_load_d = 1'b1;
			hop_d      = '{reloc_sum, bca_tag_q, 60'h0};
		end
	end

	// error sources
	wire logic fp_inf    = fp_result_valid && fp_exponent >= exit_bounds_pkg::INF_EXP;
	wire logic fp_indef  = fp_result_valid & fp_indefinite;
	wire logic err_oob   = exit_selection_q[exit_bounds_pkg::SEL_OOB] & third_skip_phase & oob_q;
	wire logic err_inf   = exit_selection_q[exit_bounds_pkg::SEL_INF] & fp_inf;
	wire logic err_indef = exit_selection_q[exit_bounds_pkg::SEL_INDEF] & fp_indef;
	wire logic err_set   = err_oob | err_inf | err_indef;

	wire logic stop_decode = opcode_field == exit_bounds_pkg::OPC_STOP && scoreboard_dispatch;
	wire logic delay_done  = dly_q >= 4'(exit_bounds_pkg::DELAY_CYC);

	// exit-stop sequencer
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			exit_bounds_pkg::S_IDLE:
				if (error_q)
					state_d = exit_bounds_pkg::S_DELAY;
			exit_bounds_pkg::S_DELAY:
				if (delay_done && !fetch_next_pending)
					state_d = exit_bounds_pkg::S_WRITE;
			exit_bounds_pkg::S_WRITE:
				state_d = exit_bounds_pkg::S_GAP;
			exit_bounds_pkg::S_GAP:
				if (gap_q == 4'(exit_bounds_pkg::REFETCH_CYC - 1))
					state_d = exit_bounds_pkg::S_FETCH;
			exit_bounds_pkg::S_FETCH:
				state_d = exit_bounds_pkg::S_HALT;
			exit_bounds_pkg::S_HALT:
				if (clr_stop)
					state_d = exit_bounds_pkg::S_IDLE;
			default:
				state_d = exit_bounds_pkg::S_IDLE;
		endcase
	end

	// next values of the control flags; a set always beats a clear
	wire logic [3:0] dly_d  = (state_q == exit_bounds_pkg::S_DELAY && !delay_done)
		? dly_q + 4'h1 : (state_q == exit_bounds_pkg::S_DELAY ? dly_q : 4'h0);
	wire logic [3:0] gap_d  = (state_q == exit_bounds_pkg::S_GAP) ? gap_q + 4'h1 : 4'h1;
	wire logic stop_d  = stop_decode | error_q | (stop_q & ~clr_stop);
	wire logic oob_d   = (out_of_range & bca_full_q & ~exchange_active) | (oob_q & ~clr_oob);
	wire logic seq_go  = state_q == exit_bounds_pkg::S_DELAY && state_d == exit_bounds_pkg::S_WRITE;
	wire logic error_d = err_set | (error_q & ~seq_go);
	wire logic fetch_hit = exit_mode && hop_tag_chain == exit_bounds_pkg::TAG_FETCH && mem_accept;
	wire logic fetch_d   = fetch_hit | (fetch_q & ~clr_fetch);
	wire logic jump_d    = state_q == exit_bounds_pkg::S_WRITE;
	wire logic exit_d    = jump_d | (exit_q & ~(clr_stop & state_q == exit_bounds_pkg::S_HALT));
	wire logic [2:0] code_d = (error_q | exit_busy) ? code_q : {err_indef, err_inf, err_oob};
	wire logic [17:0] pc_d = jump_d ? 18'h0 : ((pc_update & ~stop_q) ? pc_value : pc_q);

	// register file
	wire logic [31:0] status_word = {21'h0, code_q, 2'h0, exit_busy, fetch_q,
		exit_q, error_q, oob_q, stop_q};
	wire logic [31:0] rd_mux =
		(wb_adr_i == exit_bounds_pkg::OFS_EXIT_SEL) ? {29'h0, exit_selection_q} :
		(wb_adr_i == exit_bounds_pkg::OFS_FL)       ? {14'h0, field_length_q} :
		(wb_adr_i == exit_bounds_pkg::OFS_RA)       ? {14'h0, relocation_base_q} :
		(wb_adr_i == exit_bounds_pkg::OFS_STATUS)   ? status_word :
		(wb_adr_i == exit_bounds_pkg::OFS_PC)       ? {14'h0, pc_q} : 32'h0;
	wire logic [31:0] sel_new = ({29'h0, exit_selection_q} & ~lane_mask) | wr_bits;
	wire logic [31:0] fl_new  = ({14'h0, field_length_q} & ~lane_mask) | wr_bits;
	wire logic [31:0] ra_new  = ({14'h0, relocation_base_q} & ~lane_mask) | wr_bits;

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			exit_selection_q  <= exit_bounds_pkg::EXIT_SEL_RST;
			field_length_q    <= exit_bounds_pkg::FL_RST;
			relocation_base_q <= exit_bounds_pkg::RA_RST;
			ack_q             <= 1'b0;
			rdata_q           <= 32'h0;
		end
		else
		begin
			ack_q   <= bus_req;
			rdata_q <= bus_req ? rd_mux : rdata_q;
			if (wr_sel)
				exit_selection_q <= sel_new[2:0];
			if (wr_fl)
				field_length_q <= fl_new[17:0];
			if (wr_ra)
				relocation_base_q <= ra_new[17:0];
		end
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			bound_check_address_q <= 18'h0;
			bca_tag_q             <= 6'h0;
			bca_full_q            <= 1'b0;
		end
		else
		begin
			if (take_req)
			begin
				bound_check_address_q <= req_addr;
				bca_tag_q             <= req_tag;
			end
			bca_full_q <= take_req | (bca_full_q & ~send_req);
		end
	end

	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			state_q    <= exit_bounds_pkg::S_IDLE;
			stop_q     <= 1'b0;
			oob_q      <= 1'b0;
			error_q    <= 1'b0;
			exit_q     <= 1'b0;
			fetch_q    <= 1'b0;
			proceed_q  <= 1'b0;
			jump_q     <= 1'b0;
			code_q     <= 3'h0;
			pc_q       <= 18'h0;
			dly_q      <= 4'h0;
			gap_q      <= 4'h1;
			hop_load_q <= 1'b0;
			hop_q      <= '0;
		end
		else
		begin
			state_q    <= state_d;
			stop_q     <= stop_d;
			oob_q      <= oob_d;
			error_q    <= error_d;
			exit_q     <= exit_d;
			fetch_q    <= fetch_d;
			proceed_q  <= fetch_hit;
			jump_q     <= jump_d;
			code_q     <= code_d;
			pc_q       <= pc_d;
			dly_q      <= dly_d;
			gap_q      <= gap_d;
			hop_load_q <= hop_load_d;
			hop_q      <= hop_d;
		end
	end

	// outputs
	assign wb_ack_o               = ack_q;
	assign wb_dat_o               = rdata_q;
	assign hop_load               = hop_load_q;
	assign hop_req                = hop_q;
	assign stop                   = stop_q;
	assign instruction_word_fetch = fetch_q;
	assign proceed                = proceed_q;
	assign jump_launch            = jump_q;
	assign program_counter        = pc_q;

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence exit_write_seq;
		hop_load_q && hop_q.tag == exit_bounds_pkg::TAG_EXIT_WR && hop_q.addr == relocation_base_q;
	endsequence
	sequence exit_fetch_seq;
		hop_load_q && hop_q.tag == exit_bounds_pkg::TAG_FETCH && hop_q.addr == relocation_base_q;
	endsequence

	chk_normal_stop_set: assert property (
		stop_decode |=> stop_q) else $error("stop decode did not set stop");
	chk_pc_held_stop: assert property (
		(stop_q && state_q != exit_bounds_pkg::S_WRITE) |=> pc_q == $past(pc_q))
		else $error("program counter moved while stopped");
	chk_compare_result: assert property (
		out_of_range == (bound_check_address_q > field_length_q))
		else $error("bounds compare wrong");
	chk_oob_flag_set: assert property (
		(out_of_range && bca_full_q && !exchange_active) |=> oob_q)
		else $error("out of bounds flag not set");
	chk_error_from_oob: assert property (
		err_oob |=> error_q) else $error("bounds error not raised");
	chk_oob_zero_addr: assert property (
		(send_req && out_of_range) |=> hop_load_q && hop_q.addr == 18'h0 && !hop_q.tag[5])
		else $error("out of bounds request not replaced");
	chk_inbound_reloc: assert property (
		(send_req && !out_of_range) |=> hop_load_q && hop_q.addr == $past(reloc_sum))
		else $error("in-bounds request not relocated");
	chk_error_stops_cpu: assert property (
		$rose(error_q) |=> stop_q && state_q == exit_bounds_pkg::S_DELAY)
		else $error("error did not stop and start delay");
	chk_delay_waits: assert property (
		(state_q == exit_bounds_pkg::S_DELAY && fetch_next_pending)
		|=> state_q == exit_bounds_pkg::S_DELAY) else $error("delay left while fetch pending");
	chk_exit_sequence: assert property (
		seq_go |-> ##2 exit_write_seq ##3 exit_fetch_seq)
		else $error("exit write and refetch out of order");
	chk_jump_to_base: assert property (
		jump_q |-> pc_q == 18'h0 && exit_q) else $error("jump did not clear pc");
	chk_exit_proceed: assert property (
		fetch_hit |=> instruction_word_fetch && proceed)
		else $error("exit fetch did not proceed");
	chk_float_error: assert property (
		(err_inf || err_indef) |=> error_q) else $error("float error not raised");

endmodule

// *** exit_bounds_pkg.sv ***
// shared constants and carriers for the exit-mode bounds check
package exit_bounds_pkg;

	// address, tag and word widths
	localparam int ADDR_W = 18;
	localparam int TAG_W  = 6;
	localparam int WORD_W = 60;
	localparam int DIGITS = 6;

	// hopper tags (octal 10, 50, write bit 40)
	localparam logic [5:0] TAG_FETCH     = 6'h08;
	localparam logic [5:0] TAG_EXIT_WR   = 6'h28;
	localparam logic [5:0] TAG_WRITE_BIT = 6'h20;

	// stop opcode and infinite exponent threshold (octal 3777)
	localparam logic [5:0]  OPC_STOP = 6'h00;
	localparam logic [10:0] INF_EXP  = 11'h7ff;

	// exit selection bits
	localparam int SEL_OOB   = 0;
	localparam int SEL_INF   = 1;
	localparam int SEL_INDEF = 2;

	// exit word fields
	localparam int EW_OPC_LSB  = 54;
	localparam int EW_CODE_LSB = 48;
	localparam int EW_ADDR_LSB = 30;

	// register byte offsets
	localparam logic [7:0] OFS_EXIT_SEL = 8'h00;
	localparam logic [7:0] OFS_FL       = 8'h04;
	localparam logic [7:0] OFS_RA       = 8'h08;
	localparam logic [7:0] OFS_STATUS   = 8'h0c;
	localparam logic [7:0] OFS_PC       = 8'h10;

	// status bit positions
	localparam int ST_STOP  = 0;
	localparam int ST_OOB   = 1;
	localparam int ST_ERROR = 2;
	localparam int ST_EXIT  = 3;
	localparam int ST_FETCH = 4;
	localparam int ST_BUSY  = 5;
	localparam int ST_CODE  = 8;

	// reset values
	localparam logic [2:0]  EXIT_SEL_RST = 3'h0;
	localparam logic [17:0] FL_RST       = 18'h3ffff;
	localparam logic [17:0] RA_RST       = 18'h00000;

	// timing
	localparam int CLK_NS      = 100;
	localparam int DELAY_NS    = 200;
	localparam int REFETCH_NS  = 300;
	localparam int DELAY_CYC   = (DELAY_NS + CLK_NS - 1) / CLK_NS;
	localparam int REFETCH_CYC = REFETCH_NS / CLK_NS;

	// exit-stop sequencer
	typedef enum logic [2:0] {
		S_IDLE  = 3'b000,
		S_DELAY = 3'b001,
		S_WRITE = 3'b010,
		S_GAP   = 3'b011,
		S_FETCH = 3'b100,
		S_HALT  = 3'b101
	} exit_state_type;

	// entry loaded into the hopper head register
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [TAG_W-1:0]  tag;
		logic [WORD_W-1:0] data;
	} hop_req_type;

endpackage

// *** hopper_model.sv ***
// hopper and memory acceptance model at the far side of the block
`timescale 1ns/1ps
module hopper_model
(
	// clock and reset
	input  wire logic                         clk,
	input  wire logic                         nrst,
	// pacing: high grants only every other cycle
	input  wire logic                         slow,
	// from the block
	input  wire logic                         hop_load,
	input  wire exit_bounds_pkg::hop_req_type hop_req,
	// to the block
	output logic                              hopper_grant,
	output logic      [5:0]                   hop_tag_chain,
	output logic                              mem_accept
);
	logic [5:0] last_q;

	// idle chain shows the inverse of the last tag so a stale tag never looks live
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			hopper_grant  <= 1'b0;
			hop_tag_chain <= 6'h00;
			mem_accept    <= 1'b0;
			last_q        <= 6'h00;
		end
		else
		begin
			hopper_grant  <= slow ? ~hopper_grant : 1'b1;
			mem_accept    <= hop_load;
			hop_tag_chain <= hop_load ? hop_req.tag : ~last_q;
			last_q        <= hop_load ? hop_req.tag : last_q;
		end
	end
endmodule

// *** exit_mode_bounds_check_tb.sv ***
// self-checking bench for the exit-mode bounds check
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_count++; \
	$display("[ERR] t=%0t got %h exp %h", $time, (g), (e)); end end
module exit_mode_bounds_check_tb;
	logic                         clk, nrst, slow, wb_ack_o, wb_cyc_i, wb_stb_i, wb_we_i;
	logic [7:0]                   wb_adr_i;
	logic [31:0]                  wb_dat_i, wb_dat_o, q;
	logic [3:0]                   wb_sel_i;
	logic                         req_valid, req_ready, hopper_grant, mem_accept, hop_load;
	logic [17:0]                  req_addr, pc_value, program_counter;
	logic [5:0]                   req_tag, hop_tag_chain, opcode_field;
	exit_bounds_pkg::hop_req_type hop_req, r;
	logic                         exchange_active, third_skip_phase, scoreboard_dispatch;
	logic                         fetch_next_pending, pc_update, fp_result_valid, fp_indefinite;
	logic [10:0]                  fp_exponent;
	logic                         stop, instruction_word_fetch, proceed, jump_launch;
	int                           err_count, checks_done, cycles, seen;

	exit_mode_bounds_check dut (.clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
		.wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .req_valid, .req_addr, .req_tag,
		.req_ready, .hopper_grant, .hop_tag_chain, .mem_accept, .hop_load, .hop_req,
		.exchange_active, .third_skip_phase, .opcode_field, .scoreboard_dispatch,
		.fetch_next_pending, .pc_update, .pc_value, .fp_result_valid, .fp_exponent,
		.fp_indefinite, .stop, .instruction_word_fetch, .proceed, .jump_launch,
		.program_counter);
	hopper_model hop (.clk, .nrst, .slow, .hop_load, .hop_req, .hopper_grant,
		.hop_tag_chain, .mem_accept);

	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// the whole run needs well under a thousand cycles
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			err_count++;
			test_done();
		end
	end

	task test_done;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// request held until the edge that samples ack
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hf;
		// only the bench timeout ends this wait
		do
			@(posedge clk);
		while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	task send(input logic [17:0] a, input logic [5:0] t);
		int n;
		@(posedge clk);
		req_valid <= 1'b1;
		req_addr  <= a;
		req_tag   <= t;
		n = 0;
		do begin @(posedge clk); n++; end while (req_ready !== 1'b1 && n < 50);
		req_valid <= 1'b0;
	endtask

	task get_load;
		int n;
		n = 0;
		do begin @(posedge clk); n++; end while (hop_load !== 1'b1 && n < 50);
		r = hop_req;
	endtask

	task set_pc(input logic [17:0] v);
		@(posedge clk);
		pc_value  <= v;
		pc_update <= 1'b1;
		@(posedge clk);
		pc_update <= 1'b0;
		@(posedge clk);
	endtask

	task fp(input logic [10:0] e, input logic ind);
		@(posedge clk);
		fp_result_valid <= 1'b1;
		fp_exponent     <= e;
		fp_indefinite   <= ind;
		@(posedge clk);
		fp_result_valid <= 1'b0;
		fp_indefinite   <= 1'b0;
	endtask

	task t_regs;
		wb(0, 8'h00, 0);
		`CHK(q, 32'h0)
		wb(0, 8'h04, 0);
		`CHK(q, 32'h3ffff)
		wb(0, 8'h08, 0);
		`CHK(q, 32'h0)
		wb(1, 8'h00, 32'hff);
		wb(0, 8'h00, 0);
		`CHK(q, 32'h7)
		wb(1, 8'h20, 32'h5);
		wb(0, 8'h20, 0);
		`CHK(q, 32'h0)
		wb(1, 8'h00, 0);
		`CHK(stop, 1'b0)
		$display("registers test done");
	endtask

	// octal 777 limit against 1000 makes the digit compare decide
	task t_bounds;
		slow <= 1'b1;
		wb(1, 8'h04, 32'h1ff);
		wb(1, 8'h08, 32'h1000);
		send(18'h1ff, 6'h08);
		get_load();
		`CHK(r.addr, 18'h11ff)
		`CHK(r.tag, 6'h08)
		wb(0, 8'h0c, 0);
		`CHK(q[1], 1'b0)
		slow <= 1'b0;
		send(18'h200, 6'h08);
		get_load();
		`CHK(r.addr, 18'h0)
		`CHK(r.tag, 6'h08)
		wb(0, 8'h0c, 0);
		`CHK(q[1], 1'b1)
		send(18'h3ffff, 6'h2e);
		get_load();
		`CHK(r.addr, 18'h0)
		`CHK(r.tag, 6'h0e)
		send(18'h200, 6'h2f);
		get_load();
		`CHK(r.tag, 6'h0f)
		exchange_active <= 1'b1;
		wb(1, 8'h0c, 32'h12);
		send(18'h300, 6'h08);
		get_load();
		exchange_active <= 1'b0;
		wb(0, 8'h0c, 0);
		`CHK(q[1], 1'b0)
		$display("bounds test done");
	endtask

	task t_stop;
		set_pc(18'h45);
		`CHK(program_counter, 18'h45)
		opcode_field        <= 6'h01;
		scoreboard_dispatch <= 1'b1;
		@(posedge clk);
		opcode_field <= 6'h00;
		@(posedge clk);
		opcode_field        <= 6'h3f;
		scoreboard_dispatch <= 1'b0;
		`CHK(stop, 1'b0)
		@(posedge clk);
		`CHK(stop, 1'b1)
		set_pc(18'h77);
		`CHK(program_counter, 18'h45)
		wb(1, 8'h0c, 32'h13);
		$display("normal stop test done");
	endtask

	task exit_seq(input logic [2:0] code, input logic hold);
		logic [59:0] ew;
		ew = '0;
		ew[50:48] = code;
		ew[47:30] = 18'h46;
		seen = 0;
		if (hold)
		begin
			repeat (6) begin @(posedge clk); if (hop_load === 1'b1) seen++; end
			`CHK(seen, 0)
			`CHK(stop, 1'b1)
			fetch_next_pending <= 1'b0;
		end
		get_load();
		`CHK(r.tag, 6'h28)
		`CHK(r.addr, 18'h1000)
		`CHK(r.data, ew)
		// the jump pulse stands in the same cycle as the write load
		`CHK(jump_launch, 1'b1)
		`CHK(program_counter, 18'h0)
		repeat (3) @(posedge clk);
		`CHK(hop_load, 1'b1)
		`CHK(hop_req.tag, 6'h08)
		`CHK(hop_req.addr, 18'h1000)
		seen = 0;
		repeat (4) begin @(posedge clk); if (proceed === 1'b1) seen++; end
		`CHK(seen, 1)
		`CHK(instruction_word_fetch, 1'b1)
		`CHK(stop, 1'b1)
		wb(1, 8'h0c, 32'h13);
		wb(0, 8'h0c, 0);
		`CHK(q[5:0], 6'h00)
		$display("exit sequence for cause %b done", code);
	endtask

	task t_exit_oob;
		wb(1, 8'h00, 32'h1);
		send(18'h200, 6'h08);
		get_load();
		repeat (4) @(posedge clk);
		wb(0, 8'h0c, 0);
		`CHK(q[2], 1'b0)
		`CHK(stop, 1'b0)
		wb(1, 8'h0c, 32'h12);
		third_skip_phase   <= 1'b1;
		fetch_next_pending <= 1'b1;
		set_pc(18'h45);
		send(18'h200, 6'h08);
		get_load();
		`CHK(r.addr, 18'h0)
		// skip phase is a pulse; held high it would raise the error again
		third_skip_phase <= 1'b0;
		exit_seq(3'b001, 1'b1);
	endtask

	task t_exit_fp;
		wb(1, 8'h00, 32'h2);
		set_pc(18'h45);
		fp(11'h7fe, 1'b0);
		repeat (4) @(posedge clk);
		`CHK(stop, 1'b0)
		fp(11'h7ff, 1'b0);
		exit_seq(3'b010, 1'b0);
		wb(1, 8'h00, 32'h4);
		set_pc(18'h45);
		fp(11'h100, 1'b1);
		exit_seq(3'b100, 1'b0);
	endtask

	initial
	begin
		{nrst, slow, wb_cyc_i, wb_stb_i, wb_we_i, req_valid, pc_update} = '0;
		{exchange_active, third_skip_phase, scoreboard_dispatch} = '0;
		{fetch_next_pending, fp_result_valid, fp_indefinite} = '0;
		{wb_adr_i, wb_dat_i, wb_sel_i, req_addr, req_tag, pc_value, fp_exponent} = '0;
		opcode_field = 6'h3f;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		t_regs();
		t_bounds();
		t_stop();
		t_exit_oob();
		t_exit_fp();
		test_done();
	end
endmodule
